// ==== core/vgsr_pkg.sv ====
// constants, types and register map of the general and sequencer register bank
package vgsr_pkg;

  // ------------------------------------------------------------------
  // host i/o port addresses
  // ------------------------------------------------------------------
  localparam logic [15:0] PORT_MISC_WR     = 16'h03c2;
  localparam logic [15:0] PORT_STATUS_ZERO = 16'h03c2;
  localparam logic [15:0] PORT_MISC_RD     = 16'h03cc;
  localparam logic [15:0] PORT_SEQ_INDEX   = 16'h03c4;
  localparam logic [15:0] PORT_SEQ_DATA    = 16'h03c5;
  localparam logic [15:0] PORT_FEATURE_RD  = 16'h03ca;
  localparam logic [15:0] PORT_MONO_STAT   = 16'h03ba;
  localparam logic [15:0] PORT_COLOR_STAT  = 16'h03da;
  localparam logic [15:0] PORT_MONO_CRT    = 16'h03b4;
  localparam logic [15:0] PORT_COLOR_CRT   = 16'h03d4;
  localparam logic [15:0] PORT_CRT_MASK    = 16'hfffe;

  // ------------------------------------------------------------------
  // sequencer indices
  // ------------------------------------------------------------------
  localparam logic [2:0] IDX_RESET   = 3'h0;
  localparam logic [2:0] IDX_CLOCK   = 3'h1;
  localparam logic [2:0] IDX_MAPMASK = 3'h2;
  localparam logic [2:0] IDX_CHARMAP = 3'h3;
  localparam logic [2:0] IDX_MEMMODE = 3'h4;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int MISC_ADDR_SEL  = 0;
  localparam int MISC_RAM_EN    = 1;
  localparam int MISC_CLK_LO    = 2;
  localparam int MISC_CLK_HI    = 3;
  localparam int ST0_IRQ        = 7;
  localparam int ST0_SENSE      = 4;
  localparam int ST1_DIAG_HI    = 5;
  localparam int ST1_DIAG_LO    = 4;
  localparam int ST1_VRETRACE   = 3;
  localparam int ST1_DISP_OFF   = 0;
  localparam int FEAT_VSYNC_OR  = 3;
  localparam int RST_ASYNC      = 0;
  localparam int RST_SYNC       = 1;
  localparam int CLK_DOTS8      = 0;
  localparam int CLK_SHIFT_LOAD = 2;
  localparam int CLK_DOT_DIV    = 3;
  localparam int CLK_SHIFT4     = 4;
  localparam int CLK_SCREEN_OFF = 5;
  localparam int MEM_EXTENDED   = 1;
  localparam int MEM_ODD_EVEN   = 2;
  localparam int MEM_CHAIN4     = 3;

  // ------------------------------------------------------------------
  // writable bit masks and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] MASK_MISC    = 8'hef;
  localparam logic [7:0] MASK_FEAT    = 8'h08;
  localparam logic [7:0] MASK_INDEX   = 8'h07;
  localparam logic [7:0] MASK_RESET   = 8'h03;
  localparam logic [7:0] MASK_CLOCK   = 8'h3d;
  localparam logic [7:0] MASK_MAPMASK = 8'h0f;
  localparam logic [7:0] MASK_CHARMAP = 8'h3f;
  localparam logic [7:0] MASK_MEMMODE = 8'h0e;
  localparam logic [7:0] RST_VAL_SEQRST = 8'h03;
  localparam logic [7:0] RST_VAL_ZERO   = 8'h00;

  // ------------------------------------------------------------------
  // character timing
  // ------------------------------------------------------------------
  localparam logic [3:0] DOTS_NINE  = 4'h8;
  localparam logic [3:0] DOTS_EIGHT = 4'h7;
  localparam logic [1:0] LOAD_EVERY_FOURTH = 2'h3;
  localparam logic [1:0] LOAD_EVERY_OTHER  = 2'h1;
  localparam logic [1:0] LOAD_EVERY        = 2'h0;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_A    = 3'b001,
    SRC_B    = 3'b010,
    SRC_USER = 3'b100
  } vgsr_src_t;

  typedef enum logic [1:0] {
    SEQ_RUN  = 2'b01,
    SEQ_HALT = 2'b10
  } vgsr_seq_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } vgsr_io_req_t;

  typedef struct packed {
    logic       vretrace_irq;
    logic       monitor_sense_out;
    logic [7:0] pixel_bus;
    logic [1:0] plane_diag_sel;
    logic       vretrace;
    logic       display_off;
    logic       vsync;
    logic       vdisp_en;
  } vgsr_video_in_t;

  typedef struct packed {
    logic [7:0] misc;
    logic [7:0] feat;
    logic [7:0] seq_index;
    logic [7:0] seq_reset;
    logic [7:0] clock_mode;
    logic [7:0] map_mask;
    logic [7:0] char_map;
    logic [7:0] mem_mode;
    logic [7:0] rdata;
    logic       ack;
    logic       vsync_out;
    logic       dot_phase;
    logic [3:0] dot_cnt;
    logic [1:0] char_cnt;
    logic       shift_load;
    logic       char_tick;
    vgsr_seq_t  seq;
  } vgsr_state_t;

endpackage

// ==== core/vgsr_regs.sv ====
// general and sequencer register bank with sequencer timing and map write steering
//
// Behaviour
// - clock select bits choose dot clock source while cfg_bit3 low
// - video RAM access blocked while enable low
// - address select picks mono or color ports
// - status zero bit 7 shows retrace interrupt
// - status zero bit 4 shows monitor sense
// - plane enable bits pick diagnostic pixel pair
// - status one bit 3 shows vertical retrace
// - status one bit 0 shows display disabled
// - feature bit 3 ORs vsync with display enable
// - sequencer index selects data port register
// - reset bits halt sequencer sync or async
// - screen off blanks image, sync keeps running
// - shift4 loads serializers every fourth character
// - shift load picks every or other character
// - dot clock bit halves the dot rate
// - character clock is nine or eight dots
// - map mask enables host writes per map
// - font A slot from three bit selector
// - font B slot with same mapping
// - attribute bit 3 switches fonts when extended
// - chain four lets address bits pick map
// - odd even sends address parity to maps
// - extended memory bit flags more than 64KB
`timescale 1ns/1ps
module vgsr_regs
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // host i/o port
  input  wire vgsr_pkg::vgsr_io_req_t   io_req,
  output logic [7:0]                    io_rdata,
  output logic                          io_ack,
  // host video memory port
  input  wire logic                     mem_req,
  input  wire logic                     mem_wr,
  input  wire logic [1:0]               mem_addr_lo,
  output logic                          mem_grant,
  output logic [3:0]                    map_write_en,
  // video side status
  input  wire vgsr_pkg::vgsr_video_in_t video_in,
  input  wire logic                     cfg_bit3,
  input  wire logic                     attr_bit3,
  // sequencer outputs
  output vgsr_pkg::vgsr_src_t           dot_clock_sel,
  output logic                          vsync_out,
  output logic                          blank_out,
  output logic                          seq_halted,
  output logic                          dot_tick,
  output logic                          char_tick,
  output logic                          shift_load,
  output logic [3:0]                    char_width_m1,
  output logic [2:0]                    font_a_slot,
  output logic [2:0]                    font_b_slot,
  output logic [2:0]                    text_font_slot,
  output logic                          ext_memory,
  output logic                          crt_sel_color,
  output logic                          crt_port_hit
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // 8 KB slot number, 0-based: even slots for low values, odd for high
  function automatic logic [2:0] font_slot(input logic [2:0] sel);
    font_slot = {sel[1:0], sel[2]};
  endfunction

  function automatic logic [15:0] stat_port(input logic color);
    stat_port = color ? vgsr_pkg::PORT_COLOR_STAT : vgsr_pkg::PORT_MONO_STAT;
  endfunction

  vgsr_pkg::vgsr_state_t st;
  vgsr_pkg::vgsr_state_t next_st;

  logic [7:0] status_zero;
  logic [7:0] status_one;
  logic [1:0] diag_pair;
  logic       async_halt;
  logic       color_map;

  assign color_map  = st.misc[vgsr_pkg::MISC_ADDR_SEL];
  assign async_halt = ~st.seq_reset[vgsr_pkg::RST_ASYNC];

  // ------------------------------------------------------------------
  // status assembly
  // ------------------------------------------------------------------
  always_comb
  begin
    case (video_in.plane_diag_sel)
      2'b00:   diag_pair = {video_in.pixel_bus[2], video_in.pixel_bus[0]};
      2'b01:   diag_pair = {video_in.pixel_bus[5], video_in.pixel_bus[4]};
      2'b10:   diag_pair = {video_in.pixel_bus[3], video_in.pixel_bus[1]};
      default: diag_pair = {video_in.pixel_bus[7], video_in.pixel_bus[6]};
    endcase
    status_zero = 8'h00;
    status_zero[vgsr_pkg::ST0_IRQ]   = video_in.vretrace_irq;
    // meaningful only while active video is out
    status_zero[vgsr_pkg::ST0_SENSE] = video_in.monitor_sense_out;
    status_one = 8'h00;
    status_one[vgsr_pkg::ST1_DIAG_HI]  = diag_pair[1];
    status_one[vgsr_pkg::ST1_DIAG_LO]  = diag_pair[0];
    status_one[vgsr_pkg::ST1_VRETRACE] = video_in.vretrace;
    status_one[vgsr_pkg::ST1_DISP_OFF] = video_in.display_off;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic [3:0] width_m1;
    logic [1:0] load_div;
    logic       dtick;
    logic       ctick;
    width_m1 = 4'h0;
    load_div = 2'h0;
    dtick    = 1'b0;
    ctick    = 1'b0;
    next_st = st;
    next_st.ack   = 1'b0;
    next_st.rdata = 8'h00;

    // host writes; the index register steers the data port
    if (io_req.wr)
    begin
      next_st.ack = 1'b1;
      case (io_req.addr)
        vgsr_pkg::PORT_MISC_WR:
          next_st.misc = io_req.wdata & vgsr_pkg::MASK_MISC;
        vgsr_pkg::PORT_SEQ_INDEX:
          next_st.seq_index = io_req.wdata & vgsr_pkg::MASK_INDEX;
        vgsr_pkg::PORT_SEQ_DATA:
          case (st.seq_index[2:0])
            vgsr_pkg::IDX_RESET:   next_st.seq_reset  = io_req.wdata & vgsr_pkg::MASK_RESET;
            vgsr_pkg::IDX_CLOCK:   next_st.clock_mode = io_req.wdata & vgsr_pkg::MASK_CLOCK;
            vgsr_pkg::IDX_MAPMASK: next_st.map_mask   = io_req.wdata & vgsr_pkg::MASK_MAPMASK;
            vgsr_pkg::IDX_CHARMAP: next_st.char_map   = io_req.wdata & vgsr_pkg::MASK_CHARMAP;
            vgsr_pkg::IDX_MEMMODE: next_st.mem_mode   = io_req.wdata & vgsr_pkg::MASK_MEMMODE;
            default:               next_st.ack        = 1'b0;
          endcase
        default:
          if (io_req.addr == stat_port(color_map))
            next_st.feat = io_req.wdata & vgsr_pkg::MASK_FEAT;
          else
            next_st.ack = 1'b0;
      endcase
    end
    else if (io_req.rd)
    begin
      next_st.ack = 1'b1;
      case (io_req.addr)
        vgsr_pkg::PORT_STATUS_ZERO: next_st.rdata = status_zero;
        vgsr_pkg::PORT_MISC_RD:     next_st.rdata = st.misc;
        vgsr_pkg::PORT_FEATURE_RD:  next_st.rdata = st.feat;
        vgsr_pkg::PORT_SEQ_INDEX:   next_st.rdata = st.seq_index;
        vgsr_pkg::PORT_SEQ_DATA:
          case (st.seq_index[2:0])
            vgsr_pkg::IDX_RESET:   next_st.rdata = st.seq_reset;
            vgsr_pkg::IDX_CLOCK:   next_st.rdata = st.clock_mode;
            vgsr_pkg::IDX_MAPMASK: next_st.rdata = st.map_mask;
            vgsr_pkg::IDX_CHARMAP: next_st.rdata = st.char_map;
            vgsr_pkg::IDX_MEMMODE: next_st.rdata = st.mem_mode;
            default:               next_st.rdata = 8'h00;
          endcase
        default:
          if (io_req.addr == stat_port(color_map))
            next_st.rdata = status_one;
          else
            next_st.ack = 1'b0;
      endcase
    end

    // sync output gating
    next_st.vsync_out = st.feat[vgsr_pkg::FEAT_VSYNC_OR] ?
                        (video_in.vsync | video_in.vdisp_en) : video_in.vsync;

    // character timing
    width_m1 = st.clock_mode[vgsr_pkg::CLK_DOTS8] ?
               vgsr_pkg::DOTS_EIGHT : vgsr_pkg::DOTS_NINE;
    if (st.clock_mode[vgsr_pkg::CLK_SHIFT4])
      load_div = vgsr_pkg::LOAD_EVERY_FOURTH;
    else if (st.clock_mode[vgsr_pkg::CLK_SHIFT_LOAD])
      load_div = vgsr_pkg::LOAD_EVERY_OTHER;
    else
      load_div = vgsr_pkg::LOAD_EVERY;
    next_st.char_tick  = 1'b0;
    next_st.shift_load = 1'b0;

    case (st.seq)
      vgsr_pkg::SEQ_RUN:
      begin
        next_st.dot_phase = ~st.dot_phase;
        dtick = ~st.clock_mode[vgsr_pkg::CLK_DOT_DIV] | st.dot_phase;
        if (dtick)
        begin
          ctick = (st.dot_cnt >= width_m1);
          next_st.dot_cnt = ctick ? 4'h0 : st.dot_cnt + 4'h1;
        end
        if (ctick)
        begin
          next_st.char_tick  = 1'b1;
          next_st.shift_load = ((st.char_cnt & load_div) == 2'h0);
          next_st.char_cnt   = st.char_cnt + 2'h1;
        end
        // synchronous halt waits for a character boundary
        if (~st.seq_reset[vgsr_pkg::RST_SYNC] & ctick)
          next_st.seq = vgsr_pkg::SEQ_HALT;
      end
      vgsr_pkg::SEQ_HALT:
      begin
        next_st.dot_phase = 1'b0;
        next_st.dot_cnt   = 4'h0;
        next_st.char_cnt  = 2'h0;
        if (&st.seq_reset[1:0])
          next_st.seq = vgsr_pkg::SEQ_RUN;
      end
      default:
        next_st.seq = vgsr_pkg::SEQ_HALT;
    endcase

    // asynchronous halt clears at once, without waiting for a boundary
    if (async_halt)
    begin
      next_st.seq        = vgsr_pkg::SEQ_HALT;
      next_st.dot_phase  = 1'b0;
      next_st.dot_cnt    = 4'h0;
      next_st.char_cnt   = 2'h0;
      next_st.char_tick  = 1'b0;
      next_st.shift_load = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st            <= '0;
      st.seq_reset  <= vgsr_pkg::RST_VAL_SEQRST;
      st.misc       <= vgsr_pkg::RST_VAL_ZERO;
      st.seq        <= vgsr_pkg::SEQ_RUN;
    end
    else
      st <= next_st;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  always_comb
  begin
    case (st.misc[vgsr_pkg::MISC_CLK_HI:vgsr_pkg::MISC_CLK_LO])
      2'b00:   dot_clock_sel = vgsr_pkg::SRC_A;
      2'b01:   dot_clock_sel = cfg_bit3 ? vgsr_pkg::SRC_A : vgsr_pkg::SRC_B;
      default: dot_clock_sel = cfg_bit3 ? vgsr_pkg::SRC_A : vgsr_pkg::SRC_USER;
    endcase
  end

  assign io_rdata      = st.rdata;
  assign io_ack        = st.ack;
  assign mem_grant     = mem_req & st.misc[vgsr_pkg::MISC_RAM_EN];
  assign crt_sel_color = color_map;
  assign crt_port_hit  = (io_req.rd | io_req.wr) &&
                         ((io_req.addr & vgsr_pkg::PORT_CRT_MASK) ==
                          (color_map ? vgsr_pkg::PORT_COLOR_CRT : vgsr_pkg::PORT_MONO_CRT));

  always_comb
  begin
    logic [3:0] steer;
    steer = 4'hf;
    if (st.mem_mode[vgsr_pkg::MEM_CHAIN4])
      steer = 4'h1 << mem_addr_lo;
    else if (!st.mem_mode[vgsr_pkg::MEM_ODD_EVEN])
      steer = mem_addr_lo[0] ? 4'ha : 4'h5;
    map_write_en = (mem_grant & mem_wr) ? (steer & st.map_mask[3:0]) : 4'h0;
  end

  assign vsync_out      = st.vsync_out;
  assign seq_halted     = (st.seq == vgsr_pkg::SEQ_HALT) | async_halt;
  assign blank_out      = st.clock_mode[vgsr_pkg::CLK_SCREEN_OFF] | seq_halted;
  assign dot_tick       = (st.seq == vgsr_pkg::SEQ_RUN) & ~async_halt &
                          (~st.clock_mode[vgsr_pkg::CLK_DOT_DIV] | st.dot_phase);
  assign char_tick      = st.char_tick;
  assign shift_load     = st.shift_load;
  assign char_width_m1  = st.clock_mode[vgsr_pkg::CLK_DOTS8] ?
                          vgsr_pkg::DOTS_EIGHT : vgsr_pkg::DOTS_NINE;
  assign font_a_slot    = font_slot({st.char_map[5], st.char_map[3:2]});
  assign font_b_slot    = font_slot({st.char_map[4], st.char_map[1:0]});
  assign ext_memory     = st.mem_mode[vgsr_pkg::MEM_EXTENDED];
  assign text_font_slot = (ext_memory & ~attr_bit3) ? font_b_slot : font_a_slot;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_stat_read;
    io_req.rd && !io_req.wr && io_req.addr == vgsr_pkg::PORT_STATUS_ZERO;
  endsequence

  // host strobes one cycle and then idles one before the data port access
  sequence s_index_then_data;
    io_req.wr && io_req.addr == vgsr_pkg::PORT_SEQ_INDEX &&
      io_req.wdata == 8'h02 ##1
    !io_req.wr ##1
    io_req.wr && io_req.addr == vgsr_pkg::PORT_SEQ_DATA;
  endsequence

  a_grant_blocked: assert property (@(posedge clk) disable iff (!rst_n)
    !st.misc[vgsr_pkg::MISC_RAM_EN] |-> !mem_grant && map_write_en == 4'h0)
    else $error("memory access granted while disabled");

  a_irq_status: assert property (@(posedge clk) disable iff (!rst_n)
    s_stat_read |=> io_ack && io_rdata[7] == $past(video_in.vretrace_irq))
    else $error("status zero bit 7 wrong");

  a_sense_status: assert property (@(posedge clk) disable iff (!rst_n)
    s_stat_read |=> io_rdata[4] == $past(video_in.monitor_sense_out) && io_rdata[3:0] == 4'h0)
    else $error("status zero bit 4 wrong");

  a_vsync_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 vsync_out == ($past(st.feat[3]) ? $past(video_in.vsync | video_in.vdisp_en)
                                        : $past(video_in.vsync)))
    else $error("vsync gating wrong");

  a_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
    s_index_then_data |=> st.map_mask == ($past(io_req.wdata) & 8'h0f))
    else $error("map mask not written through index");

  a_async_halt: assert property (@(posedge clk) disable iff (!rst_n)
    async_halt |-> seq_halted && !dot_tick ##1 (!char_tick && !shift_load))
    else $error("async halt not immediate");

  a_char_width: assert property (@(posedge clk) disable iff (!rst_n)
    st.dot_cnt <= vgsr_pkg::DOTS_NINE)
    else $error("dot counter past nine dots");

  a_screen_off: assert property (@(posedge clk) disable iff (!rst_n)
    st.clock_mode[5] |-> blank_out)
    else $error("screen off did not blank");

  a_chain4_one: assert property (@(posedge clk) disable iff (!rst_n)
    st.mem_mode[3] && mem_grant && mem_wr |-> $onehot0(map_write_en))
    else $error("chain four hit several maps");

  a_font_slot: assert property (@(posedge clk) disable iff (!rst_n)
    font_a_slot[0] == st.char_map[5] && font_a_slot[2:1] == st.char_map[3:2])
    else $error("font A slot mapping wrong");

endmodule

// ==== verification/tb_vgsr_regs.sv ====
// self-checking bench for the general and sequencer register bank
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_vgsr_regs;
  logic clk = 1'b0, rst_n = 1'b0, mem_req = 1'b0, mem_wr = 1'b0;
  logic cfg_bit3 = 1'b0, attr_bit3 = 1'b0, ok;
  logic [1:0] mem_addr_lo = 2'h0;
  logic [2:0] fa, fb, font_a_slot, font_b_slot, text_font_slot;
  logic [3:0] map_write_en, char_width_m1;
  logic [7:0] q, io_rdata;
  logic io_ack, mem_grant, vsync_out, blank_out, seq_halted, dot_tick, char_tick;
  logic shift_load, ext_memory, crt_sel_color, crt_port_hit;
  vgsr_pkg::vgsr_video_in_t video_in = '0;
  vgsr_pkg::vgsr_io_req_t   io_req;
  vgsr_pkg::vgsr_src_t      dot_clock_sel;
  int fails = 0, checks_done = 0, i, j;
  logic [7:0] msk [5] = '{8'h03, 8'h3d, 8'h0f, 8'h3f, 8'h0e};
  logic [7:0] cm [2] = '{8'h16, 8'h29};
  // 0-based slots: selector 0-3 lands on even slots, 4-7 on odd ones
  logic [2:0] fsl [2][2] = '{'{3'h2, 3'h5}, '{3'h5, 3'h2}};
  int crt_hits = 0;
  logic [2:0] vt [3] = '{3'b101, 3'b001, 3'b010};
  logic [7:0] cmv [6] = '{8'h00, 8'h01, 8'h04, 8'h10, 8'h14, 8'h09};
  int eg [6][3] = '{'{1, 9, 9}, '{1, 8, 8}, '{1, 9, 18}, '{1, 9, 36}, '{1, 9, 36}, '{2, 16, 16}};

  always #5 clk = ~clk;
  always @(posedge clk)
    if (crt_port_hit === 1'b1)
      crt_hits++;

  vgsr_host host_u (.clk(clk), .io_rdata(io_rdata), .io_ack(io_ack), .io_req(io_req));
  vgsr_regs dut_u
  (
    .clk(clk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata), .io_ack(io_ack),
    .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr_lo(mem_addr_lo), .mem_grant(mem_grant),
    .map_write_en(map_write_en), .video_in(video_in), .cfg_bit3(cfg_bit3),
    .attr_bit3(attr_bit3), .dot_clock_sel(dot_clock_sel), .vsync_out(vsync_out),
    .blank_out(blank_out), .seq_halted(seq_halted), .dot_tick(dot_tick),
    .char_tick(char_tick), .shift_load(shift_load), .char_width_m1(char_width_m1),
    .font_a_slot(font_a_slot), .font_b_slot(font_b_slot), .text_font_slot(text_font_slot),
    .ext_memory(ext_memory), .crt_sel_color(crt_sel_color), .crt_port_hit(crt_port_hit)
  );

  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d, q, ok);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    host_u.xfer(1'b0, a, 8'h00, q, ok);
    `CHK(ok, 1'b1)
    `CHK(q, e)
  endtask
  task automatic seq(input int x, input logic [7:0] d);
    wr(vgsr_pkg::PORT_SEQ_INDEX, {5'h00, x[2:0]});
    wr(vgsr_pkg::PORT_SEQ_DATA, d);
  endtask
  task automatic seqrd(input int x, input logic [7:0] e);
    wr(vgsr_pkg::PORT_SEQ_INDEX, {5'h00, x[2:0]});
    rdc(vgsr_pkg::PORT_SEQ_DATA, e);
  endtask
  // cycles between the second and third pulse; 100 means none came
  task automatic gap(input int s, input int e);
    int k = 0;
    int n = 0;
    logic [2:0] tk;
    while (k < 3 && n < 100)
    begin
      @(negedge clk);
      n++;
      tk = {shift_load, char_tick, dot_tick};
      if (tk[s] === 1'b1)
      begin
        k++;
        if (k < 3)
          n = 0;
      end
    end
    `CHK(n, e)
  endtask
  task automatic conclude();
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #200_000;
    fails++;
    conclude();
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CHK(dot_clock_sel, vgsr_pkg::SRC_A)
    `CHK(blank_out, 1'b0)
    for (i = 0; i < 5; i++)
      seqrd(i, (i == 0) ? 8'h03 : 8'h00);
    for (i = 0; i < 5; i++)
    begin
      seq(i, 8'hff);
      seqrd(i, msk[i]);
    end
    wr(vgsr_pkg::PORT_SEQ_INDEX, 8'hff);
    rdc(vgsr_pkg::PORT_SEQ_INDEX, 8'h07);
    rdc(vgsr_pkg::PORT_SEQ_DATA, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      wr(vgsr_pkg::PORT_MISC_WR, {4'h0, i[1:0], 2'b11});
      `CHK(dot_clock_sel, (i == 0) ? vgsr_pkg::SRC_A : (i == 1) ? vgsr_pkg::SRC_B : vgsr_pkg::SRC_USER)
      cfg_bit3 = 1'b1;
      #1 `CHK(dot_clock_sel, vgsr_pkg::SRC_A)
      cfg_bit3 = 1'b0;
    end
    rdc(vgsr_pkg::PORT_MISC_RD, 8'h0f);
    `CHK(crt_sel_color, 1'b1)
    host_u.xfer(1'b0, vgsr_pkg::PORT_MONO_STAT, 8'h00, q, ok);
    `CHK(ok, 1'b0)
    host_u.xfer(1'b1, vgsr_pkg::PORT_COLOR_CRT + 16'h0001, 8'h00, q, ok);
    host_u.xfer(1'b0, vgsr_pkg::PORT_MONO_CRT, 8'h00, q, ok);
    `CHK(crt_hits, 1)
    mem_req = 1'b1;
    mem_wr = 1'b1;
    wr(vgsr_pkg::PORT_MISC_WR, 8'h0d);
    `CHK(mem_grant, 1'b0)
    wr(vgsr_pkg::PORT_MISC_WR, 8'h0f);
    `CHK(mem_grant, 1'b1)
    seq(vgsr_pkg::IDX_MAPMASK, 8'h0b);
    seq(vgsr_pkg::IDX_MEMMODE, 8'h04);
    mem_addr_lo = 2'h1;
    #1 `CHK(map_write_en, 4'hb)
    seq(vgsr_pkg::IDX_MEMMODE, 8'h00);
    `CHK(map_write_en, 4'ha)
    mem_addr_lo = 2'h2;
    #1 `CHK(map_write_en, 4'h1)
    mem_addr_lo = 2'h3;
    seq(vgsr_pkg::IDX_MEMMODE, 8'h0c);
    `CHK(map_write_en, 4'h8)
    seq(vgsr_pkg::IDX_MEMMODE, 8'h02);
    `CHK(ext_memory, 1'b1)
    for (j = 0; j < 2; j++)
    begin
      seq(vgsr_pkg::IDX_CHARMAP, cm[j]);
      fa = fsl[j][0];
      fb = fsl[j][1];
      `CHK(font_a_slot, fa)
      `CHK(font_b_slot, fb)
      attr_bit3 = 1'b1;
      #1 `CHK(text_font_slot, fa)
      @(negedge clk) attr_bit3 = 1'b0;
      #1 `CHK(text_font_slot, fb)
    end
    // sense is read while screen off from clock mode 3d blanks the picture
    for (j = 0; j < 2; j++)
    begin
      video_in.vretrace_irq = j[0];
      video_in.monitor_sense_out = ~j[0];
      rdc(vgsr_pkg::PORT_STATUS_ZERO, j[0] ? 8'h80 : 8'h10);
    end
    // with d8 each selected pair equals its selector, inverted for 27
    for (j = 0; j < 8; j++)
    begin
      video_in.pixel_bus = j[2] ? 8'h27 : 8'hd8;
      video_in.plane_diag_sel = j[1:0];
      video_in.vretrace = j[0];
      video_in.display_off = j[1];
      rdc(vgsr_pkg::PORT_COLOR_STAT, {2'b00, j[1:0] ^ {2{j[2]}}, j[0], 2'b00, j[1]});
    end
    seq(vgsr_pkg::IDX_CLOCK, 8'h20);
    `CHK(blank_out, 1'b1)
    for (j = 0; j < 3; j++)
    begin
      wr(vgsr_pkg::PORT_COLOR_STAT, {4'h0, vt[j][2], 3'h7});
      rdc(vgsr_pkg::PORT_FEATURE_RD, {4'h0, vt[j][2], 3'h0});
      video_in.vsync = vt[j][1];
      video_in.vdisp_en = vt[j][0];
      repeat (2) @(negedge clk);
      `CHK(vsync_out, vt[j][1] | (vt[j][2] & vt[j][0]))
    end
    for (j = 0; j < 6; j++)
    begin
      seq(vgsr_pkg::IDX_CLOCK, cmv[j]);
      `CHK(char_width_m1, cmv[j][0] ? 4'h7 : 4'h8)
      gap(0, eg[j][0]);
      gap(1, eg[j][1]);
      gap(2, eg[j][2]);
    end
    seq(vgsr_pkg::IDX_RESET, 8'h02);
    `CHK(seq_halted, 1'b1)
    seq(vgsr_pkg::IDX_RESET, 8'h03);
    repeat (20) @(negedge clk);
    `CHK(seq_halted, 1'b0)
    seq(vgsr_pkg::IDX_RESET, 8'h01);
    repeat (20) @(negedge clk);
    `CHK(seq_halted, 1'b1)
    `CHK(blank_out, 1'b1)
    gap(1, 100);
    conclude();
  end
endmodule

// ==== verification/vgsr_host.sv ====
// host i/o port model issuing single-strobe port accesses
`timescale 1ns/1ps
module vgsr_host
(
  // clock
  input  wire logic              clk,
  // device answer
  input  wire logic [7:0]        io_rdata,
  input  wire logic              io_ack,
  // host request
  output vgsr_pkg::vgsr_io_req_t io_req
);
  initial io_req = '0;
  // one strobe cycle; the answer is picked up where it stands, one cycle on
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    @(negedge clk);
    io_req = '{rd: ~w, wr: w, addr: a, wdata: d};
    @(negedge clk);
    // released lines show the inverse so a stale copy is never trusted
    io_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    ok = io_ack;
    q = io_rdata;
  endtask
endmodule
